// [pkg/mdw_defs.vh]
`ifndef MDW_DEFS_VH
`define MDW_DEFS_VH
// Timing
`define MDW_CLK_MHZ        50
`define MDW_EXEC_NS        500
`define MDW_EXEC_CYC       ((`MDW_EXEC_NS * `MDW_CLK_MHZ + 999) / 1000)
// Instruction queue
`define MDW_FIFO_DEPTH     120
`define MDW_PTR_LAST       7'd119
`define MDW_FIFO_FULL      7'd120
// Instruction word fields
`define MDW_FRAME_BITS     5'd24
`define MDW_F_GRP_HI       23
`define MDW_F_GRP_LO       20
`define MDW_F_CH_HI        19
`define MDW_F_CH_LO        16
`define MDW_F_SEL_HI       15
`define MDW_F_SEL_LO       14
`define MDW_F_DATA_HI      13
`define MDW_GRP_ALL        4'hF
`define MDW_CH_PER_GRP     10
`define MDW_NUM_CH         40
`define MDW_SEL_SPECIAL    2'b00
`define MDW_SOFT_RST_CODE  14'h3FFF
// Register offsets
`define MDW_REG_STATUS     8'h00
`define MDW_REG_EXEC       8'h04
`define MDW_REG_LAST       8'h08
`define MDW_REG_DIRTY_LO   8'h0C
`define MDW_REG_DIRTY_HI   8'h10
`define MDW_REG_DROPS      8'h14
// Status bit positions
`define MDW_ST_BUSY        8
`define MDW_ST_GROUND      9
`define MDW_ST_PEND        10
`define MDW_ST_PAWAKE      11
`define MDW_ST_SAWAKE      12
`define MDW_ST_PSEL        13
// Reset values and response codes
`define MDW_EXEC_RST       8'h19
`define MDW_RESP_OKAY      2'b00
`define MDW_RESP_SLVERR    2'b10
`endif

// [rtl/mdw_fifo_mem.v]
`timescale 1ns/1ps
`default_nettype none
`include "mdw_defs.vh"
module mdw_fifo_mem (
  input  wire        aclk,
  input  wire        wr_en,
  input  wire [6:0]  wr_addr,
  input  wire [23:0] wr_data,
  input  wire        rd_en,
  input  wire [6:0]  rd_addr,
  output reg  [23:0] rd_data
);
  reg [23:0] mem [0:`MDW_FIFO_DEPTH-1];

  always @(posedge aclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (rd_en)
      rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [rtl/mdw_serial_rx.v]
`timescale 1ns/1ps
`default_nettype none
`include "mdw_defs.vh"
module mdw_serial_rx (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        enable,
  input  wire        chain_enable,
  input  wire        sclk,
  input  wire        sync_n,
  input  wire        sdin,
  output reg         word_valid,
  output reg  [23:0] word,
  output reg         chain_out,
  output reg         awake
);
  reg [1:0]  sclk_s;
  reg [1:0]  sync_s;
  reg [1:0]  din_s;
  reg [1:0]  chain_enable_s;
  reg        sclk_d;
  reg        sync_d;
  reg [23:0] shreg;
  reg [4:0]  cnt;
  wire       sclk_fall = sclk_d & ~sclk_s[1];
  wire       sclk_rise = ~sclk_d & sclk_s[1];
  wire       sync_fall = sync_d & ~sync_s[1];
  wire       sync_rise = ~sync_d & sync_s[1];
  wire       chain     = chain_enable_s[1];
  wire       full      = (cnt == `MDW_FRAME_BITS);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_s     <= 2'h3;
      sync_s     <= 2'h3;
      din_s      <= 2'h0;
      chain_enable_s     <= 2'h0;
      sclk_d     <= 1'b1;
      sync_d     <= 1'b1;
      shreg      <= 24'h000000;
      cnt        <= 5'h00;
      awake      <= 1'b0;
      word_valid <= 1'b0;
      word       <= 24'h000000;
      chain_out  <= 1'b0;
    end
    else
    begin
      sclk_s     <= {sclk_s[0], sclk};
      sync_s     <= {sync_s[0], sync_n};
      din_s      <= {din_s[0], sdin};
      chain_enable_s     <= {chain_enable_s[0], chain_enable};
      sclk_d     <= sclk_s[1];
      sync_d     <= sync_s[1];
      word_valid <= 1'b0;
      if (!enable)
        awake <= 1'b0;
      else if (sync_fall && (chain || !awake || full))
      begin
        awake <= 1'b1;
        cnt   <= 5'h00;
      end
      else if (sync_rise && awake && (chain || full))
      begin
        awake <= 1'b0;
        if (full)
        begin
          word_valid <= 1'b1;
          word       <= shreg;
        end
      end
      else if (sclk_fall && awake && (chain ? !sync_s[1] : !full))
      begin
        shreg <= {shreg[22:0], din_s[1]};
        if (!full)
          cnt <= cnt + 5'h01;
      end
      if (sclk_rise && chain && awake && !sync_s[1])
        chain_out <= shreg[23];
    end
  end
endmodule
`default_nettype wire

// [rtl/mdw_write_port.v]
`timescale 1ns/1ps
`default_nettype none
`include "mdw_defs.vh"
module mdw_write_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        port_select,
  input  wire        cs_n,
  input  wire        wr_n,
  input  wire        dest_select_hi,
  input  wire        dest_select_lo,
  input  wire [13:0] parallel_word,
  input  wire [7:0]  channel_address,
  input  wire        sclk,
  input  wire        sync_n,
  input  wire        sdin,
  input  wire        chain_enable,
  output wire        chain_out,
  input  wire        output_clear_n,
  input  wire        load_outputs_n,
  output reg         busy_n,
  output reg         ref_ground_level,
  output reg         load_strobe,
  output reg  [39:0] load_mask,
  output reg         exec_valid,
  output reg  [7:0]  exec_address,
  output reg  [1:0]  exec_dest,
  output reg  [13:0] exec_word,
  output reg         soft_reset,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_EXEC = 3'b100;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0]  psel_s;
  reg [1:0]  wr_s;
  reg [1:0]  cs_s;
  reg [1:0]  clr_s;
  reg [1:0]  ld_s;
  reg [23:0] pw_s0;
  reg [23:0] pw_s1;
  reg        wr_d;
  reg        ld_d;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      psel_s <= 2'h0;
      wr_s   <= 2'h3;
      cs_s   <= 2'h3;
      clr_s  <= 2'h3;
      ld_s   <= 2'h3;
      pw_s0  <= 24'h000000;
      pw_s1  <= 24'h000000;
      wr_d   <= 1'b1;
      ld_d   <= 1'b1;
    end
    else
    begin
      psel_s <= {psel_s[0], port_select};
      wr_s   <= {wr_s[0], wr_n};
      cs_s   <= {cs_s[0], cs_n};
      clr_s  <= {clr_s[0], output_clear_n};
      ld_s   <= {ld_s[0], load_outputs_n};
      pw_s0  <= {channel_address, dest_select_hi, dest_select_lo, parallel_word};
      pw_s1  <= pw_s0;
      wr_d   <= wr_s[1];
      ld_d   <= ld_s[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parallel and serial capture
  reg         par_awake;
  wire        ser_mode  = psel_s[1];
  wire        par_fall  = wr_d & ~wr_s[1];
  wire        par_rise  = ~wr_d & wr_s[1];
  wire        par_valid = par_rise && !cs_s[1] && !ser_mode && par_awake;
  wire        ser_valid;
  wire [23:0] ser_word;
  wire        ser_awake;
  wire        in_valid  = par_valid || (ser_valid && ser_mode);
  wire [23:0] in_word   = ser_mode ? ser_word : pw_s1;

  always @(posedge aclk)
  begin
    if (!aresetn)
      par_awake <= 1'b0;
    else if (ser_mode)
      par_awake <= 1'b0;
    else if (par_fall)
      par_awake <= 1'b1;
    else if (par_rise)
      par_awake <= 1'b0;
  end

  mdw_serial_rx u_serial (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (ser_mode),
    .chain_enable (chain_enable),
    .sclk         (sclk),
    .sync_n       (sync_n),
    .sdin         (sdin),
    .word_valid   (ser_valid),
    .word         (ser_word),
    .chain_out    (chain_out),
    .awake        (ser_awake)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Instruction FIFO
  reg  [6:0]  wr_ptr;
  reg  [6:0]  rd_ptr;
  reg  [6:0]  count;
  reg  [7:0]  drops;
  reg  [2:0]  state;
  wire        fifo_full = (count == `MDW_FIFO_FULL);
  wire        push      = in_valid && !fifo_full;
  wire        pop       = (state == ST_IDLE) && (count != 7'h00);
  wire [23:0] rd_data;

  mdw_fifo_mem u_mem (
    .aclk    (aclk),
    .wr_en   (push),
    .wr_addr (wr_ptr),
    .wr_data (in_word),
    .rd_en   (pop),
    .rd_addr (rd_ptr),
    .rd_data (rd_data)
  );

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      count  <= 7'h00;
      drops  <= 8'h00;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == `MDW_PTR_LAST) ? 7'h00 : wr_ptr + 7'h01;
      if (pop)
        rd_ptr <= (rd_ptr == `MDW_PTR_LAST) ? 7'h00 : rd_ptr + 7'h01;
      if (push && !pop)
        count <= count + 7'h01;
      else if (pop && !push)
        count <= count - 7'h01;
      if (in_valid && fifo_full && (drops != 8'hFF))
        drops <= drops + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Execution
  reg  [23:0] cur;
  reg  [7:0]  exec_cnt;
  reg  [7:0]  exec_cycles;
  reg  [39:0] dirty;
  wire [39:0] cur_mask;
  wire [3:0]  cur_grp   = cur[`MDW_F_GRP_HI:`MDW_F_GRP_LO];
  wire [3:0]  cur_ch    = cur[`MDW_F_CH_HI:`MDW_F_CH_LO];
  wire [1:0]  cur_sel   = cur[`MDW_F_SEL_HI:`MDW_F_SEL_LO];
  wire [13:0] cur_data  = cur[`MDW_F_DATA_HI:0];
  wire        cur_srst  = (cur_sel == `MDW_SEL_SPECIAL) && (cur_data == `MDW_SOFT_RST_CODE);
  wire        exec_done = (state == ST_EXEC) && (exec_cnt == 8'h01);
  wire        busy_now  = (state != ST_IDLE) || (count != 7'h00);

  genvar gi;
  generate
    for (gi = 0; gi < `MDW_NUM_CH; gi = gi + 1)
    begin : g_mask
      localparam integer GRP = gi / `MDW_CH_PER_GRP;
      localparam integer CH  = gi % `MDW_CH_PER_GRP;
      assign cur_mask[gi] = ((cur_grp == GRP[3:0]) || (cur_grp == `MDW_GRP_ALL)) &&
                            (cur_ch == CH[3:0]);
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state        <= ST_IDLE;
      cur          <= 24'h000000;
      exec_cnt     <= 8'h00;
      exec_valid   <= 1'b0;
      exec_address <= 8'h00;
      exec_dest    <= 2'h0;
      exec_word    <= 14'h0000;
      soft_reset   <= 1'b0;
      busy_n       <= 1'b1;
    end
    else
    begin
      exec_valid <= 1'b0;
      soft_reset <= 1'b0;
      busy_n     <= ~busy_now;
      case (state)
        ST_IDLE:
        begin
          if (pop)
            state <= ST_READ;
        end
        ST_READ:
        begin
          cur      <= rd_data;
          exec_cnt <= (exec_cycles == 8'h00) ? 8'h01 : exec_cycles;
          state    <= ST_EXEC;
        end
        ST_EXEC:
        begin
          exec_cnt <= exec_cnt - 8'h01;
          if (exec_done)
          begin
            exec_valid   <= 1'b1;
            exec_address <= cur[`MDW_F_GRP_HI:`MDW_F_CH_LO];
            exec_dest    <= cur_sel;
            exec_word    <= cur_data;
            soft_reset   <= cur_srst;
            state        <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clear and load
  reg         load_pend;
  wire        ld_fall  = ld_d & ~ld_s[1];
  wire        do_load  = clr_s[1] && !busy_now &&
                         (ld_fall || load_pend || (!busy_n && !ld_s[1]));
  wire [39:0] set_mask = !exec_done ? 40'h0000000000 :
                         cur_srst ? {40{1'b1}} : cur_mask;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_pend        <= 1'b0;
      ref_ground_level <= 1'b0;
      load_strobe      <= 1'b0;
      load_mask        <= 40'h0000000000;
      dirty            <= 40'h0000000000;
    end
    else
    begin
      load_strobe <= 1'b0;
      dirty       <= (do_load ? 40'h0000000000 : dirty) | set_mask;
      if (!clr_s[1])
      begin
        ref_ground_level <= 1'b1;
        load_pend        <= 1'b0;
      end
      else if (do_load)
      begin
        load_strobe      <= 1'b1;
        load_mask        <= dirty;
        ref_ground_level <= 1'b0;
        load_pend        <= 1'b0;
      end
      else if (ld_fall && busy_now)
        load_pend <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [23:0] last_word;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  wire        aw_held   = !s_axi_awready;
  wire        w_held    = !s_axi_wready;
  wire        wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire        ar_go     = s_axi_arvalid && s_axi_arready;
  wire        wr_exec   = wr_go && (aw_addr == `MDW_REG_EXEC);

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `MDW_REG_STATUS:
      begin
        rd_mux[6:0]           = count;
        rd_mux[`MDW_ST_BUSY]   = busy_now;
        rd_mux[`MDW_ST_GROUND] = ref_ground_level;
        rd_mux[`MDW_ST_PEND]   = load_pend;
        rd_mux[`MDW_ST_PAWAKE] = par_awake;
        rd_mux[`MDW_ST_SAWAKE] = ser_awake;
        rd_mux[`MDW_ST_PSEL]   = ser_mode;
      end
      `MDW_REG_EXEC:     rd_mux[7:0]  = exec_cycles;
      `MDW_REG_LAST:     rd_mux[23:0] = last_word;
      `MDW_REG_DIRTY_LO: rd_mux       = dirty[31:0];
      `MDW_REG_DIRTY_HI: rd_mux[7:0]  = dirty[39:32];
      `MDW_REG_DROPS:    rd_mux[7:0]  = drops;
      default:           rd_hit       = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MDW_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MDW_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      exec_cycles   <= `MDW_EXEC_RST;
      last_word     <= 24'h000000;
    end
    else
    begin
      if (push)
        last_word <= in_word;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_exec || aw_addr == `MDW_REG_STATUS ||
                         aw_addr == `MDW_REG_LAST || aw_addr == `MDW_REG_DIRTY_LO ||
                         aw_addr == `MDW_REG_DIRTY_HI || aw_addr == `MDW_REG_DROPS) ?
                        `MDW_RESP_OKAY : `MDW_RESP_SLVERR;
        if (wr_exec && w_strb[0])
          exec_cycles <= w_data[7:0];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_go)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? `MDW_RESP_OKAY : `MDW_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/mdw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mdw_host_model (
  input  wire logic   aclk,
  input  wire logic   chain_out,
  output logic        port_select,
  output logic        cs_n,
  output logic        wr_n,
  output logic        dest_select_hi,
  output logic        dest_select_lo,
  output logic [13:0] parallel_word,
  output logic [7:0]  channel_address,
  output logic        sclk,
  output logic        sync_n,
  output logic        sdin,
  output logic        chain_enable,
  output logic [23:0] chain_seen
);
  initial
  begin
    {port_select, cs_n, wr_n, dest_select_hi, dest_select_lo} = 5'h0C;
    {parallel_word, channel_address} = 22'h0;
    {sclk, sync_n, sdin, chain_enable} = 4'h4;
    chain_seen = 24'h0;
  end
  ////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task set_mode(input logic ps, input logic ce);
    @(posedge aclk);
    port_select <= ps;
    chain_enable <= ce;
  endtask
  task par_write(input logic [7:0] a, input logic [1:0] d, input logic [13:0] w,
                 input logic cs);
    @(posedge aclk);
    cs_n <= cs;
    channel_address <= a;
    {dest_select_hi, dest_select_lo} <= d;
    parallel_word <= w;
    wr_n <= 1'b0;
    tick(4);
    wr_n <= 1'b1;
    tick(4);
    cs_n <= 1'b1;
    parallel_word <= ~w;
    channel_address <= ~a;
  endtask
  task ser_frame(input logic [47:0] b, input int n, input int g);
    @(posedge aclk);
    sync_n <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      sclk <= 1'b1;
      sdin <= b[n-1-i];
      if (i == g) sync_n <= 1'b1;
      tick(3);
      sync_n <= 1'b0;
      tick(1);
      sclk <= 1'b0;
      chain_seen <= {chain_seen[22:0], chain_out};
      tick(4);
    end
    tick(4);
    sync_n <= 1'b1;
    sdin <= ~sdin;
    tick(8);
  endtask
endmodule
`default_nettype wire

// [verification/mdw_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module mdw_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        chain_enable,
  input wire logic        output_clear_n,
  input wire logic        busy_n,
  input wire logic        ref_ground_level,
  input wire logic        load_strobe,
  input wire logic        exec_valid,
  input wire logic [1:0]  exec_dest,
  input wire logic [13:0] exec_word,
  input wire logic        soft_reset,
  input wire logic        chain_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_soft;
    soft_reset |-> exec_valid && exec_dest == 2'h0 && exec_word == 14'h3FFF;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset without code");
  property p_exec_busy;
    exec_valid |-> !busy_n;
  endproperty
  a_exec_busy: assert property (p_exec_busy) else $error("busy high in exec");
  property p_busy_exec;
    $fell(busy_n) |-> ##[1:300] exec_valid;
  endproperty
  a_busy_exec: assert property (p_busy_exec) else $error("busy without exec");
  property p_load_idle;
    load_strobe |-> busy_n;
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("load while busy");
  property p_clr_grd;
    (!output_clear_n)[*4] |=> ref_ground_level;
  endproperty
  a_clr_grd: assert property (p_clr_grd) else $error("clear not grounded");
  property p_clr_ld;
    (!output_clear_n)[*4] |=> !load_strobe;
  endproperty
  a_clr_ld: assert property (p_clr_ld) else $error("load during clear");
  property p_grd_rel;
    $fell(ref_ground_level) |-> load_strobe;
  endproperty
  a_grd_rel: assert property (p_grd_rel) else $error("ground left w/o load");
  property p_chain;
    $changed(chain_out) |-> chain_enable;
  endproperty
  a_chain: assert property (p_chain) else $error("chain out moved");
  c_soft: cover property (soft_reset);
  c_load: cover property (load_strobe);
  c_chain: cover property ($changed(chain_out));
endmodule
bind mdw_write_port mdw_monitor i_mdw_monitor (.aclk(aclk), .aresetn(aresetn),
  .chain_enable(chain_enable), .output_clear_n(output_clear_n), .busy_n(busy_n),
  .ref_ground_level(ref_ground_level), .load_strobe(load_strobe),
  .exec_valid(exec_valid), .exec_dest(exec_dest), .exec_word(exec_word),
  .soft_reset(soft_reset), .chain_out(chain_out));
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mdw_defs.vh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn, output_clear_n, load_outputs_n, busy_n, ref_ground_level;
  logic        port_select, cs_n, wr_n, dest_select_hi, dest_select_lo, sclk, sync_n;
  logic        sdin, chain_enable, chain_out, load_strobe, exec_valid, soft_reset;
  logic [13:0] parallel_word, exec_word;
  logic [7:0]  channel_address, exec_address, s_axi_awaddr, s_axi_araddr;
  logic [39:0] load_mask, last_mask;
  logic [23:0] chain_seen;
  logic [1:0]  exec_dest, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          miscompares = 0, n_checks = 0, n_load = 0, n_soft = 0;
  logic [23:0] got_q[$], exp_q[$];
  mdw_write_port i_mdw_write_port (.*);
  mdw_host_model i_mdw_host_model (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (exec_valid === 1'b1) got_q.push_back({exec_address, exec_dest, exec_word});
    if (load_strobe === 1'b1) n_load++;
    if (load_strobe === 1'b1) last_mask = load_mask;
    if (soft_reset === 1'b1) n_soft++;
  end
  ////////////////////////////////////////
  task wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [47:0] s, input logic [47:0] e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
  endtask
  task idle;
    int k;
    k = 0;
    cyc(10);
    while (busy_n !== 1'b1 && k < 40000)
    begin
      cyc(1);
      k++;
    end
    chk("idle", busy_n, 1'b1);
    cyc(4);
  endtask
  task drain;
    idle;
    while (exp_q.size() > 0)
      chk("exec", got_q.size() ? got_q.pop_front() : 24'hX, exp_q.pop_front());
    chk("extra", got_q.size(), 0);
  endtask
  task pw(input logic [7:0] a, input logic [1:0] ds, input logic [13:0] w);
    i_mdw_host_model.par_write(a, ds, w, 1'b0);
    exp_q.push_back({a, ds, w});
  endtask
  task ld;
    @(posedge aclk);
    load_outputs_n <= 1'b0;
    cyc(4);
    load_outputs_n <= 1'b1;
    cyc(6);
  endtask
  initial
  begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    wrap_up;
  end
  ////////////////////////////////////////
  initial
  begin
    {aresetn, output_clear_n, load_outputs_n, s_axi_wstrb} = 7'h3F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    aresetn = 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(5);
    axi_rd(`MDW_REG_EXEC, d, `MDW_RESP_OKAY);
    chk("exec_rst", d, 32'h19);
    axi_wr(8'h40, 32'h0, `MDW_RESP_SLVERR);
    axi_rd(8'h40, d, `MDW_RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    pw(8'h01, 2'b11, 14'h2001);
    pw(8'h29, 2'b10, 14'h0156);
    pw(8'hF0, 2'b01, 14'h1FFF);
    pw(8'h13, 2'b00, 14'h0055);
    i_mdw_host_model.par_write(8'h05, 2'b11, 14'h1111, 1'b1);
    i_mdw_host_model.ser_frame(48'hABCDEF, 24, 99);
    drain;
    ld;
    chk("mask", last_mask, 40'h0060102403);
    ld;
    chk("mask2", last_mask, 40'h0);
    pw(8'h32, 2'b11, 14'h0ABC);
    cyc(2);
    ld;
    chk("held", n_load, 2);
    drain;
    chk("late", n_load, 3);
    chk("mask3", last_mask, 40'h0100000000);
    output_clear_n <= 1'b0;
    cyc(6);
    chk("grd", ref_ground_level, 1'b1);
    ld;
    chk("clr_ld", n_load, 3);
    output_clear_n <= 1'b1;
    cyc(6);
    chk("grd_hold", ref_ground_level, 1'b1);
    ld;
    chk("grd_off", ref_ground_level, 1'b0);
    pw(8'h00, 2'b00, `MDW_SOFT_RST_CODE);
    drain;
    chk("soft", n_soft, 1);
    ld;
    chk("mask_all", last_mask, 40'hFFFFFFFFFF);
    i_mdw_host_model.set_mode(1'b1, 1'b0);
    cyc(4);
    i_mdw_host_model.par_write(8'h07, 2'b11, 14'h0007, 1'b0);
    exp_q.push_back({8'h12, 2'b11, 14'h2A5C});
    i_mdw_host_model.ser_frame({20'h0, 8'h12, 2'b11, 14'h2A5C, 4'h9}, 28, 5);
    drain;
    axi_rd(`MDW_REG_LAST, d, `MDW_RESP_OKAY);
    chk("last", d, 32'h0012EA5C);
    i_mdw_host_model.set_mode(1'b1, 1'b1);
    cyc(4);
    exp_q.push_back({8'h21, 2'b10, 14'h1234});
    i_mdw_host_model.ser_frame({8'h03, 2'b01, 14'h0F0F, 8'h21, 2'b10, 14'h1234}, 48, 99);
    chk("chain", chain_seen, {8'h03, 2'b01, 14'h0F0F});
    drain;
    i_mdw_host_model.set_mode(1'b0, 1'b0);
    axi_wr(`MDW_REG_EXEC, 32'hFF, `MDW_RESP_OKAY);
    axi_rd(`MDW_REG_EXEC, d, `MDW_RESP_OKAY);
    chk("exec_rw", d, 32'hFF);
    for (int i = 0; i < 135; i++) i_mdw_host_model.par_write(8'h00, 2'b11, i[13:0], 1'b0);
    idle;
    axi_rd(`MDW_REG_DROPS, d, `MDW_RESP_OKAY);
    chk("total", got_q.size() + d[7:0], 135);
    chk("dropped", d[7:0] > 8'h00, 1'b1);
    for (int i = 0; i < 100; i++) chk("order", got_q[i][13:0], i[13:0]);
    wrap_up;
  end
endmodule
`default_nettype wire
